// >>> mac_checker.sv
module mac_checker
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [15:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [15:0] rd_data,
    // Interrupt
    input wire logic irq
);
    logic opw;
    logic enw;
    logic clw;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    assign opw = wr_en && (addr == 4'h1 || addr == 4'h2);
    assign enw = wr_en && addr == 4'h7;
    assign clw = wr_en && addr == 4'h8;

    a_reset_quiet: assert property (
        $rose(rstn) |-> rd_data == 16'h0000 && !irq)
        else $error("outputs not quiet after reset");
    a_rd_idle_zero: assert property (
        !$past(rd_en) |-> rd_data == 16'h0000)
        else $error("read data outside read slot");
    a_ctrl_ro_bits: assert property (
        $past(rd_en) && $past(addr) == 4'h0
        |-> rd_data[15:8] == 8'h00 && !rd_data[5])
        else $error("control fixed bits not zero");
    a_ctrl_readback: assert property (
        wr_en && addr == 4'h0 ##1 rd_en && addr == 4'h0
        |=> (rd_data & 16'h005f) == ($past(wr_data, 2) & 16'h005f))
        else $error("control readback mismatch");
    a_clear_zeroes: assert property (
        wr_en && addr == 4'h0 && wr_data[5] ##1
        rd_en && addr inside {[4'h1:4'h5]} |=> rd_data == 16'h0000)
        else $error("data register not cleared");
    a_unmapped_zero: assert property (
        $past(rd_en) && $past(addr) > 4'h8 |-> rd_data == 16'h0000)
        else $error("unmapped read not zero");
    a_irq_cause: assert property (
        $rose(irq) |-> $past(opw) || $past(opw, 2) || $past(opw, 3)
        || $past(enw) || $past(enw, 2))
        else $error("interrupt rose without cause");
    a_irq_fall: assert property (
        $fell(irq) |-> $past(enw) || $past(clw) || $past(enw, 2)
        || $past(clw, 2))
        else $error("interrupt fell without cause");
endmodule : mac_checker

bind mac_top mac_checker u_chk
(
    .clk(clk),
    .rstn(rstn),
    .addr(addr),
    .wr_data(wr_data),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rd_data(rd_data),
    .irq(irq)
);

// >>> mac_core.sv
module mac_core
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Operation
    mac_op_if.core op
);

    typedef struct packed {
        mac_pkg::mac_core_state_t state;
        logic overflow;
        logic [47:0] result;
    } mac_core_st_t;

    mac_core_st_t s_reg;
    mac_core_st_t s_next;

    logic [48:0] prod;
    logic [48:0] acc_x;
    logic [48:0] sum;
    logic [31:0] p32;

    always_comb
    begin
        s_next = s_reg;
        s_next.state = mac_pkg::MAC_IDLE;
        if (op.unsigned_sel)
        begin
            p32 = op.opa * op.opb;
            prod = {17'h0_0000, p32};
            acc_x = {1'b0, op.acc_in};
        end
        else
        begin
            p32 = 32'($signed(op.opa) * $signed(op.opb));
            prod = {{17{p32[31]}}, p32};
            acc_x = {op.acc_in[47], op.acc_in};
        end
        unique case ({op.subtract, op.accumulate})
            2'b00: sum = prod;
            2'b01: sum = acc_x + prod;
            2'b10: sum = 49'h0 - prod;
            2'b11: sum = acc_x - prod;
        endcase
        if (op.start && !op.abort)
        begin
            s_next.state = mac_pkg::MAC_DONE;
            s_next.result = sum[47:0];
            s_next.overflow = op.unsigned_sel ? sum[48] : (sum[48] != sum[47]);
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_reg <= '{mac_pkg::MAC_IDLE, 1'b0, mac_pkg::ACC_RESET};
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign op.done = (s_reg.state == mac_pkg::MAC_DONE) && !op.abort;
    assign op.overflow = s_reg.overflow;
    assign op.result = s_reg.result;

endmodule : mac_core

// >>> mac_irq.sv
module mac_irq
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Events
    input wire logic [1:0] events,
    // Software access
    input wire logic en_wr,
    input wire logic clr_wr,
    input wire logic [1:0] wdata,
    // State
    output logic [1:0] status,
    output logic [1:0] enable,
    output logic irq
);

    typedef struct packed {
        logic [1:0] status;
        logic [1:0] enable;
        logic irq;
    } mac_irq_st_t;

    mac_irq_st_t s_reg;
    mac_irq_st_t s_next;

    always_comb
    begin
        s_next = s_reg;
        // A new event outweighs a clear in the same cycle
        if (clr_wr)
        begin
            s_next.status = s_reg.status & ~wdata;
        end
        s_next.status = s_next.status | events;
        if (en_wr)
        begin
            s_next.enable = wdata;
        end
        s_next.irq = |(s_next.status & s_next.enable);
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_reg <= '{2'h0, 2'h0, 1'b0};
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign status = s_reg.status;
    assign enable = s_reg.enable;
    assign irq = s_reg.irq;

endmodule : mac_irq

// >>> mac_op_if.sv
interface mac_op_if;
    logic start;
    logic abort;
    logic unsigned_sel;
    logic accumulate;
    logic subtract;
    logic [15:0] opa;
    logic [15:0] opb;
    logic [47:0] acc_in;
    logic done;
    logic overflow;
    logic [47:0] result;

    modport ctrl
    (
        output start, abort, unsigned_sel, accumulate, subtract,
        output opa, opb, acc_in,
        input done, overflow, result
    );

    modport core
    (
        input start, abort, unsigned_sel, accumulate, subtract,
        input opa, opb, acc_in,
        output done, overflow, result
    );
endinterface : mac_op_if

// >>> mac_pkg.sv
package mac_pkg;

    localparam int unsigned DATA_W = 16;
    localparam int unsigned ACC_W = 48;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned EVT_W = 2;

    // Register indices
    localparam logic [3:0] IDX_CTRL = 4'h0;
    localparam logic [3:0] IDX_OPA = 4'h1;
    localparam logic [3:0] IDX_OPB = 4'h2;
    localparam logic [3:0] IDX_ACC_HI = 4'h3;
    localparam logic [3:0] IDX_ACC_MID = 4'h4;
    localparam logic [3:0] IDX_ACC_LO = 4'h5;
    localparam logic [3:0] IDX_IRQ_STAT = 4'h6;
    localparam logic [3:0] IDX_IRQ_EN = 4'h7;
    localparam logic [3:0] IDX_IRQ_CLR = 4'h8;

    // Control field positions
    localparam int unsigned B_SIGNEDNESS = 0;
    localparam int unsigned B_ACCUMULATE = 1;
    localparam int unsigned B_SUBTRACT = 2;
    localparam int unsigned B_OPCOUNT = 3;
    localparam int unsigned B_SQUARE = 4;
    localparam int unsigned B_CLEAR = 5;
    localparam int unsigned B_INHIBIT = 6;
    localparam int unsigned B_OVERFLOW = 7;

    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CTRL_WMASK = 16'h005f;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [47:0] ACC_RESET = 48'h0000_0000_0000;

    // Event bits
    localparam int unsigned EV_DONE = 0;
    localparam int unsigned EV_OVF = 1;

    typedef enum logic [1:0] {
        MAC_IDLE = 2'b01,
        MAC_DONE = 2'b10
    } mac_core_state_t;

endpackage : mac_pkg

// >>> mac_top.sv
// Contract
// - Control register resets to zero
// - Bits 7 to 15 are read-only
// - Signedness bit zero means signed operands
// - Count bit zero: start after both writes
// - Count bit one: start on any write
// - Square mode ignores operand count bit
// - Square: write loads both, starts squaring
// - Square off: trigger from count bit
// - Clear bit zeroes data, self-clears
// - Inhibit bit keeps accumulator unchanged
// - Overflow flag set, cleared on start/clear
//
// The address-and-strobe port was chosen for this implementation.
module mac_top
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [15:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [15:0] rd_data,
    // Interrupt
    output logic irq
);

    typedef struct packed {
        logic [15:0] ctrl;
        logic overflow_flag;
        logic [15:0] operand_a;
        logic [15:0] operand_b;
        logic [47:0] accumulator;
        logic a_seen;
        logic b_seen;
        logic [15:0] rd_data;
    } mac_top_st_t;

    mac_top_st_t s_reg;
    mac_top_st_t s_next;

    mac_op_if op_bus ();

    // Decoded strobes and operation inputs
    logic [1:0] irq_status;
    logic [1:0] irq_enable;
    logic [1:0] events;
    logic clear_unit;
    logic start;
    logic wr_a;
    logic wr_b;
    logic wr_ctrl;
    logic wr_irq_en;
    logic wr_irq_clr;
    logic [15:0] opa_now;
    logic [15:0] opb_now;
    logic [47:0] acc_now;
    logic [15:0] rd_word;

    function automatic logic hit(input logic [3:0] idx);
        hit = wr_en && (addr == idx);
    endfunction : hit

    mac_core u_core
    (
        .clk(clk),
        .rstn(rstn),
        .op(op_bus.core)
    );

    mac_irq u_irq
    (
        .clk(clk),
        .rstn(rstn),
        .events(events),
        .en_wr(wr_irq_en),
        .clr_wr(wr_irq_clr),
        .wdata(wr_data[1:0]),
        .status(irq_status),
        .enable(irq_enable),
        .irq(irq)
    );

    // Events reported to the interrupt block
    always_comb
    begin
        events = 2'h0;
        events[mac_pkg::EV_DONE] = op_bus.done;
        events[mac_pkg::EV_OVF] = op_bus.done && op_bus.overflow;
    end

    // Register write strobes
    assign wr_ctrl = hit(mac_pkg::IDX_CTRL);
    assign wr_a = hit(mac_pkg::IDX_OPA);
    assign wr_b = hit(mac_pkg::IDX_OPB);
    assign wr_irq_en = hit(mac_pkg::IDX_IRQ_EN);
    assign wr_irq_clr = hit(mac_pkg::IDX_IRQ_CLR);

    // Clear acts on the write itself; the bit is never held
    assign clear_unit = wr_ctrl && wr_data[mac_pkg::B_CLEAR];

    // Operand values seen by an operation started this cycle
    always_comb
    begin
        opa_now = s_reg.operand_a;
        opb_now = s_reg.operand_b;
        if (wr_a)
        begin
            opa_now = wr_data;
            if (s_reg.ctrl[mac_pkg::B_SQUARE])
            begin
                opb_now = wr_data;
            end
        end
        if (wr_b)
        begin
            opb_now = wr_data;
            if (s_reg.ctrl[mac_pkg::B_SQUARE])
            begin
                opa_now = wr_data;
            end
        end
    end

    // Result of the finishing operation is forwarded to a new start unless the inhibit bit is set
    always_comb
    begin
        acc_now = s_reg.accumulator;
        if (op_bus.done && !s_reg.ctrl[mac_pkg::B_INHIBIT])
        begin
            acc_now = op_bus.result;
        end
    end

    always_comb
    begin
        start = 1'b0;
        // Square overrides the count bit
        if (s_reg.ctrl[mac_pkg::B_SQUARE])
        begin
            start = wr_a || wr_b;
        end
        else if (s_reg.ctrl[mac_pkg::B_OPCOUNT])
        begin
            start = wr_a || wr_b;
        end
        else
        begin
            // Count bit zero waits for both operands
            start = (wr_a || s_reg.a_seen) && (wr_b || s_reg.b_seen)
                && (wr_a || wr_b);
        end
    end

    // Operation request to the core
    assign op_bus.start = start;
    assign op_bus.abort = clear_unit;
    assign op_bus.unsigned_sel = s_reg.ctrl[mac_pkg::B_SIGNEDNESS];
    assign op_bus.accumulate = s_reg.ctrl[mac_pkg::B_ACCUMULATE];
    assign op_bus.subtract = s_reg.ctrl[mac_pkg::B_SUBTRACT];
    assign op_bus.opa = opa_now;
    assign op_bus.opb = opb_now;
    assign op_bus.acc_in = acc_now;

    // Read multiplexer; the word is registered on the strobe
    always_comb
    begin
        rd_word = mac_pkg::DATA_RESET;
        unique case (addr)
            mac_pkg::IDX_CTRL:
            begin
                rd_word = s_reg.ctrl;
                rd_word[mac_pkg::B_OVERFLOW] =
                    s_reg.overflow_flag;
            end
            mac_pkg::IDX_OPA:
            begin
                rd_word = s_reg.operand_a;
            end
            mac_pkg::IDX_OPB:
            begin
                rd_word = s_reg.operand_b;
            end
            mac_pkg::IDX_ACC_HI:
            begin
                rd_word = s_reg.accumulator[47:32];
            end
            mac_pkg::IDX_ACC_MID:
            begin
                rd_word = s_reg.accumulator[31:16];
            end
            mac_pkg::IDX_ACC_LO:
            begin
                rd_word = s_reg.accumulator[15:0];
            end
            mac_pkg::IDX_IRQ_STAT:
            begin
                rd_word = {14'h0000, irq_status};
            end
            mac_pkg::IDX_IRQ_EN:
            begin
                rd_word = {14'h0000, irq_enable};
            end
            default:
            begin
                rd_word = mac_pkg::DATA_RESET;
            end
        endcase
    end

    always_comb
    begin
        s_next = s_reg;
        s_next.rd_data = mac_pkg::DATA_RESET;

        // Control register write
        if (wr_ctrl)
        begin
            s_next.ctrl = wr_data & mac_pkg::CTRL_WMASK;
        end

        // Operation result
        if (op_bus.done)
        begin
            if (!s_reg.ctrl[mac_pkg::B_INHIBIT])
            begin
                s_next.accumulator = op_bus.result;
            end
            s_next.overflow_flag = op_bus.overflow;
        end

        // Direct accumulator writes
        if (hit(mac_pkg::IDX_ACC_HI))
        begin
            s_next.accumulator[47:32] = wr_data;
        end
        if (hit(mac_pkg::IDX_ACC_MID))
        begin
            s_next.accumulator[31:16] = wr_data;
        end
        if (hit(mac_pkg::IDX_ACC_LO))
        begin
            s_next.accumulator[15:0] = wr_data;
        end

        // Operand loads
        if (wr_a || wr_b)
        begin
            s_next.operand_a = op_bus.opa;
            s_next.operand_b = op_bus.opb;
            s_next.a_seen = s_reg.a_seen || wr_a;
            s_next.b_seen = s_reg.b_seen || wr_b;
        end

        // A start restarts the operand count
        if (start)
        begin
            s_next.a_seen = 1'b0;
            s_next.b_seen = 1'b0;
            s_next.overflow_flag = 1'b0;
        end

        // Clear outweighs everything before it
        if (clear_unit)
        begin
            s_next.operand_a = mac_pkg::DATA_RESET;
            s_next.operand_b = mac_pkg::DATA_RESET;
            s_next.accumulator = mac_pkg::ACC_RESET;
            s_next.overflow_flag = 1'b0;
            s_next.a_seen = 1'b0;
            s_next.b_seen = 1'b0;
        end

        // Read data stands one cycle only
        if (rd_en)
        begin
            s_next.rd_data = rd_word;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_reg.ctrl <= mac_pkg::CTRL_RESET;
            s_reg.overflow_flag <= 1'b0;
            s_reg.operand_a <= mac_pkg::DATA_RESET;
            s_reg.operand_b <= mac_pkg::DATA_RESET;
            s_reg.accumulator <= mac_pkg::ACC_RESET;
            s_reg.a_seen <= 1'b0;
            s_reg.b_seen <= 1'b0;
            s_reg.rd_data <= mac_pkg::DATA_RESET;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign rd_data = s_reg.rd_data;

endmodule : mac_top

// >>> testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk;
    logic rstn;
    logic [3:0] addr;
    logic [15:0] wr_data;
    logic wr_en;
    logic rd_en;
    logic [15:0] rd_data;
    logic irq;
    logic [15:0] v;
    logic [47:0] acc;
    int miscompares;
    int tests_run;
`define C(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
    miscompares++; $display("FAIL %s exp %h got %h", n, e, g); end end

    mac_top DUT
    (
        .clk(clk),
        .rstn(rstn),
        .addr(addr),
        .wr_data(wr_data),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .rd_data(rd_data),
        .irq(irq)
    );

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    // Back-to-back writes must not reassign the strobe in one step
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        if (wr_en)
            @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(posedge clk);
        v = rd_data;
    endtask : rd

    task automatic rd_acc();
        rd(4'h3);
        acc[47:32] = v;
        rd(4'h4);
        acc[31:16] = v;
        rd(4'h5);
        acc[15:0] = v;
    endtask : rd_acc

    // Write that starts an operation, then wait for the result
    task automatic go(input logic [3:0] a, input logic [15:0] d);
        wr(a, d);
        repeat (2) @(posedge clk);
    endtask : go

    function automatic logic [47:0] model(input logic [15:0] c,
        input logic [15:0] a, input logic [15:0] b, input logic [47:0] m);
        logic [47:0] p;
        p = c[0] ? {32'h0, a} * {32'h0, b}
            : {{32{a[15]}}, a} * {{32{b[15]}}, b};
        case (c[2:1])
            2'b00: model = p;
            2'b01: model = m + p;
            2'b10: model = -p;
            default: model = m - p;
        endcase
    endfunction : model

    task automatic t_reset();
        rd(4'h0);
        `C("ctrl", 16'h0000, v)
        `C("irq", 1'b0, irq)
        wr(4'h0, 16'hffff);
        rd(4'h0);
        `C("ctrl", 16'h005f, v)
    endtask : t_reset

    task automatic t_ops();
        logic [15:0] c;
        for (int i = 0; i < 8; i++)
        begin
            c = 16'h0008 | 16'(i);
            wr(4'h0, c);
            go(4'h2, 16'h0003);
            wr(4'h3, 16'h0000);
            wr(4'h4, 16'h0001);
            wr(4'h5, 16'h0000);
            go(4'h1, 16'hfffe);
            rd_acc();
            `C("acc", model(c, 16'hfffe, 16'h3, 48'h10000), acc)
        end
    endtask : t_ops

    task automatic t_count();
        wr(4'h0, 16'h0020);
        rd(4'h1);
        `C("opa", 16'h0000, v)
        rd_acc();
        `C("acc", 48'h0, acc)
        go(4'h1, 16'h0005);
        rd_acc();
        `C("acc", 48'h0, acc)
        go(4'h2, 16'h0007);
        rd_acc();
        `C("acc", 48'h23, acc)
    endtask : t_count

    task automatic t_square();
        wr(4'h0, 16'h0010);
        go(4'h2, 16'h0009);
        rd(4'h1);
        `C("opa", 16'h0009, v)
        rd(4'h2);
        `C("opb", 16'h0009, v)
        rd_acc();
        `C("acc", 48'h51, acc)
        wr(4'h0, 16'h0048);
        go(4'h1, 16'h0002);
        rd_acc();
        `C("acc", 48'h51, acc)
    endtask : t_square

    task automatic t_ovf();
        wr(4'h7, 16'h0003);
        rd(4'h7);
        `C("enable", 16'h0003, v)
        wr(4'h0, 16'h000d);
        go(4'h1, 16'h0001);
        rd(4'h0);
        `C("ctrl", 16'h008d, v)
        `C("irq", 1'b1, irq)
        wr(4'h6, 16'h0000);
        rd(4'h6);
        `C("status", 16'h0003, v)
        wr(4'h0, 16'h0009);
        go(4'h1, 16'h0001);
        rd(4'h0);
        `C("ctrl", 16'h0009, v)
        wr(4'h0, 16'h000d);
        go(4'h1, 16'h0001);
        wr(4'h0, 16'h002d);
        rd(4'h0);
        `C("ctrl", 16'h000d, v)
    endtask : t_ovf

    task automatic t_irq();
        wr(4'h8, 16'h0003);
        rd(4'h6);
        `C("status", 16'h0000, v)
        `C("irq", 1'b0, irq)
        wr(4'h7, 16'h0000);
        go(4'h1, 16'h0001);
        rd(4'h6);
        `C("status", 16'h0001, v)
        `C("irq", 1'b0, irq)
        wr(4'h9, 16'hffff);
        rd(4'h9);
        `C("unmapped", 16'h0000, v)
    endtask : t_irq

    initial
    begin
        repeat (5000) @(posedge clk);
        miscompares++;
        close_out();
    end

    initial
    begin
        rstn = 1'b0;
        addr = 4'h0;
        wr_data = 16'h0000;
        wr_en = 1'b0;
        rd_en = 1'b0;
        miscompares = 0;
        tests_run = 0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_ops();
        t_count();
        t_square();
        t_ovf();
        t_irq();
        close_out();
    end
endmodule : testbench
